// File: common/centered_pulse_output_pkg.sv
// Register map, field positions, reset values and types of the PWM timer
package centered_pulse_output_pkg;

   // Register byte offsets, one 32-bit word each
   localparam logic [7:0] OFF_TSC  = 8'h00;  // timer_status_control
   localparam logic [7:0] OFF_CNTH = 8'h04;  // counter_high
   localparam logic [7:0] OFF_CNTL = 8'h08;  // counter_low
   localparam logic [7:0] OFF_MODH = 8'h0C;  // modulus_high
   localparam logic [7:0] OFF_MODL = 8'h10;  // modulus_low
   localparam logic [7:0] OFF_CSC  = 8'h14;  // channel_status_control
   localparam logic [7:0] OFF_CVH  = 8'h18;  // chan_value_high
   localparam logic [7:0] OFF_CVL  = 8'h1C;  // chan_value_low

   // Field positions in timer_status_control
   localparam int TSC_FLAG = 7;  // overflow_flag
   localparam int TSC_IE   = 6;  // overflow_irq_enable
   localparam int TSC_UPDN = 5;  // updown_count_select

   // Field positions in channel_status_control
   localparam int CSC_FLAG = 7;  // channel flag
   localparam int CSC_IE   = 6;  // channel_irq_enable
   localparam int CSC_MODE = 4;  // Mode field, bits 5:4
   localparam int CSC_EDGE = 3;  // Capture edge, 1 rising
   localparam int CSC_POL  = 2;  // output_polarity_select

   // Reset values
   localparam logic [7:0]  TSC_RST = 8'h00;
   localparam logic [7:0]  CSC_RST = 8'h00;
   localparam logic [15:0] MOD_RST = 16'h0000;
   localparam logic [15:0] VAL_RST = 16'h0000;

   // Channel modes, field order fixes the codes
   typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_PWM, MODE_PWM_ALT} chan_mode_e;

   // Counter direction
   typedef enum logic {DIR_UP, DIR_DOWN} count_dir_e;

endpackage : centered_pulse_output_pkg

// File: rtl/pair_buffer.sv
// Coherent sixteen-bit register loaded from two buffered byte writes
`timescale 1ns/1ps
module pair_buffer #(
   parameter logic [15:0] RESET_VALUE = 16'h0000
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Byte writes
   input  wire logic        write_high,
   input  wire logic        write_low,
   input  wire logic [7:0]  wdata,
   // Control
   input  wire logic        cancel,    // Drop pending bytes
   input  wire logic        load_ok,   // Transfer allowed now
   // Result
   output logic      [15:0] active,
   output logic             pending    // Both bytes held
);

   logic [7:0] hold_high;  // Buffered upper byte
   logic [7:0] hold_low;   // Buffered lower byte
   logic       got_high;   // Upper byte written
   logic       got_low;    // Lower byte written
   wire        do_load = pending & load_ok & ~cancel;

   assign pending = got_high & got_low;

   ////////////////////////////////////////////////////////////////////
   // Holding bytes and pairing tracker; cancel beats everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_high <= 8'h00;
         hold_low  <= 8'h00;
         got_high  <= 1'b0;
         got_low   <= 1'b0;
      end else begin
         if (do_load) begin
            got_high <= 1'b0;
            got_low  <= 1'b0;
         end
         if (write_high) begin
            hold_high <= wdata;
            got_high  <= 1'b1;
         end
         if (write_low) begin
            hold_low <= wdata;
            got_low  <= 1'b1;
         end
         if (cancel) begin
            got_high <= 1'b0;
            got_low  <= 1'b0;
         end
      end
   end

   // Active value moves only once the pair is whole
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) active <= RESET_VALUE;
      else if (do_load) active <= {hold_high, hold_low};
   end

endmodule : pair_buffer

// File: rtl/pwm_channel.sv
// One timer channel: compare match, input capture edge and centred output
`timescale 1ns/1ps
module pwm_channel (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Counter state
   input  wire logic [15:0] cnt,
   input  wire logic [15:0] modulus,
   input  wire logic        dir_down,
   input  wire logic        tick,
   input  wire logic        center,    // Up/down mode active
   // Channel setup
   input  wire logic [15:0] value,
   input  wire logic [1:0]  mode,
   input  wire logic        rise_edge,
   input  wire logic        polarity,
   // Pins and events
   input  wire logic        capture_in,
   output logic             event_hit,  // Flag set pulse
   output logic             pwm_out
);

   logic cap_prev;  // Last capture pin level
   logic act;       // Pulse active level before polarity
   logic next_act;

   wire match    = tick & (cnt == value);
   wire is_cap   = (mode == centered_pulse_output_pkg::MODE_CAPTURE) & ~center;
   wire edge_hit = rise_edge ? (capture_in & ~cap_prev) : (~capture_in & cap_prev);
   wire val_ok   = (value != 16'h0000) & ~value[15];

   assign event_hit = is_cap ? edge_hit : match;

   // Output level: special values override the match-driven state
   always_comb begin
      if (!val_ok) next_act = 1'b0;
      else if (value > modulus) next_act = 1'b1;
      else if (match & ~dir_down) next_act = 1'b0;
      else if (match & dir_down) next_act = 1'b1;
      else next_act = act;
   end

   ////////////////////////////////////////////////////////////////////
   // Pin registers; outside up/down mode the pin idles at polarity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_prev <= 1'b0;
         act      <= 1'b0;
         pwm_out  <= 1'b0;
      end else begin
         cap_prev <= capture_in;
         act      <= next_act;
         pwm_out  <= center ? (polarity ^ next_act) : polarity;
      end
   end

endmodule : pwm_channel

// File: rtl/center_aligned_pwm_timer.sv
// Sixteen-bit PWM timer with one channel and APB register access
//
// What this block does
// - Up/down select: channel sets width, modulus period
// - Centred period equals twice the modulus
// - Zero or negative channel value gives 0%
// - Value above modulus gives 100% duty
// - Polarity 0: up-match low, down-match high
// - Count up to modulus, down to zero
// - Byte writes land in holding buffers
// - Load after both bytes and turnaround in up/down mode
// - Compare channels load without waiting outside up/down mode
// - Rewritten PWM buffers load together in up/down mode
// - Status/control write cancels modulus bytes
// - Channel control write cancels value bytes
// - Capture edge sets the channel flag
// - Counter equal to value sets flag
// - Flag and enable hold interrupt request
// - Flag clears by read then zero-write
// - New event between steps keeps flag
// - Up-count overflow at wrap to zero
// - Up/down overflow at turn from modulus
// - Any counter byte write zeroes counter
`timescale 1ns/1ps
module center_aligned_pwm_timer (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Timer pins
   input  wire logic        count_enable,  // Prescaler strobe
   input  wire logic        capture_in,
   output logic             pwm_out,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic [15:0]          cnt;           // counter_value
   logic [15:0]          next_cnt;
   centered_pulse_output_pkg::count_dir_e dir;           // Counting direction
   centered_pulse_output_pkg::count_dir_e next_dir;
   logic [7:0]           tsc;           // Control bits of timer_status_control
   logic [7:0]           csc;           // Control bits of channel_status_control
   logic                 ovf_flag;      // overflow_flag
   logic                 ovf_armed;     // Flag was read while set
   logic                 ch_flag;       // Channel flag
   logic                 ch_armed;      // Channel flag read while set
   logic [15:0]          mod_active;    // Modulus in use
   logic [15:0]          val_active;    // Channel value in use
   logic                 mod_pending;
   logic                 val_pending;
   logic                 ch_event;      // Channel flag set pulse
   logic [7:0]           rd_byte;       // Read mux result

   ////////////////////////////////////////////////////////////////////
   // Flag step: set wins, a write ends the sequence, clears need arming
   function automatic logic [1:0] flag_step(input logic flag,
                                            input logic armed,
                                            input logic set,
                                            input logic rd_arm,
                                            input logic wr,
                                            input logic wr_bit);
      logic [1:0] r;
      r = {flag, armed};
      if (set) r = 2'b10;
      else if (wr) r = {flag & ~(armed & ~wr_bit), 1'b0};
      else if (rd_arm) r = {flag, flag};
      return r;
   endfunction : flag_step

   ////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, unmapped access answers with error

   wire setup  = psel & ~penable;
   wire access = psel & penable;
   wire hit_tsc  = paddr == centered_pulse_output_pkg::OFF_TSC;
   wire hit_cnth = paddr == centered_pulse_output_pkg::OFF_CNTH;
   wire hit_cntl = paddr == centered_pulse_output_pkg::OFF_CNTL;
   wire hit_modh = paddr == centered_pulse_output_pkg::OFF_MODH;
   wire hit_modl = paddr == centered_pulse_output_pkg::OFF_MODL;
   wire hit_csc  = paddr == centered_pulse_output_pkg::OFF_CSC;
   wire hit_cvh  = paddr == centered_pulse_output_pkg::OFF_CVH;
   wire hit_cvl  = paddr == centered_pulse_output_pkg::OFF_CVL;
   wire mapped   = hit_tsc | hit_cnth | hit_cntl | hit_modh
                 | hit_modl | hit_csc | hit_cvh | hit_cvl;
   wire wr       = access & pwrite & mapped;
   wire rd       = access & ~pwrite & mapped;
   wire wr_tsc   = wr & hit_tsc;
   wire wr_csc   = wr & hit_csc;
   wire wr_cnt   = wr & (hit_cnth | hit_cntl);

   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   ////////////////////////////////////////////////////////////////////
   // Control fields

   wire        updn    = tsc[centered_pulse_output_pkg::TSC_UPDN];
   wire        ovf_ie  = tsc[centered_pulse_output_pkg::TSC_IE];
   wire        ch_ie   = csc[centered_pulse_output_pkg::CSC_IE];
   wire [1:0]  ch_mode = csc[centered_pulse_output_pkg::CSC_MODE +: 2];
   wire        ch_pol  = csc[centered_pulse_output_pkg::CSC_POL];
   wire        ch_edge = csc[centered_pulse_output_pkg::CSC_EDGE];
   wire        ch_pwm  = updn | (ch_mode[1] == 1'b1);

   ////////////////////////////////////////////////////////////////////
   // Counter step logic

   wire tick     = count_enable;
   wire dn       = dir == centered_pulse_output_pkg::DIR_DOWN;
   wire mod_nz   = mod_active != 16'h0000;
   wire at_top   = mod_nz & (cnt == mod_active);
   wire wrap     = (cnt == 16'hFFFF) | at_top;
   wire turn     = updn & ~dn & at_top;
   wire tof_set  = tick & (updn ? turn : wrap);

   // Next count: up/down reverses at modulus and at zero
   always_comb begin
      next_cnt = cnt;
      next_dir = dir;
      if (wr_cnt) begin
         next_cnt = 16'h0000;
         next_dir = centered_pulse_output_pkg::DIR_UP;
      end else if (tick && updn) begin
         if (turn) begin
            next_cnt = mod_active - 16'h0001;
            next_dir = centered_pulse_output_pkg::DIR_DOWN;
         end else if (dn && cnt <= 16'h0001) begin
            next_cnt = cnt ^ 16'h0001;
            next_dir = centered_pulse_output_pkg::DIR_UP;
         end else if (dn) begin
            next_cnt = cnt - 16'h0001;
         end else begin
            next_cnt = cnt + 16'h0001;
         end
      end else if (tick) begin
         next_cnt = wrap ? 16'h0000 : cnt + 16'h0001;
         next_dir = centered_pulse_output_pkg::DIR_UP;
      end
   end

   // Counter and direction registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 16'h0000;
         dir <= centered_pulse_output_pkg::DIR_UP;
      end else begin
         cnt <= next_cnt;
         dir <= next_dir;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Buffered modulus and channel value

   // Centred mode makes both buffered loads wait for the turnaround at modulus
   wire mod_load = updn ? tof_set : 1'b1;
   wire val_load = ch_pwm ? tof_set : 1'b1;

   pair_buffer #(
      .RESET_VALUE (centered_pulse_output_pkg::MOD_RST)
   ) u_mod_buf (
      .pclk       (pclk),
      .presetn    (presetn),
      .write_high (wr & hit_modh),
      .write_low  (wr & hit_modl),
      .wdata      (pwdata[7:0]),
      .cancel     (wr_tsc),
      .load_ok    (mod_load),
      .active     (mod_active),
      .pending    (mod_pending)
   );

   pair_buffer #(
      .RESET_VALUE (centered_pulse_output_pkg::VAL_RST)
   ) u_val_buf (
      .pclk       (pclk),
      .presetn    (presetn),
      .write_high (wr & hit_cvh),
      .write_low  (wr & hit_cvl),
      .wdata      (pwdata[7:0]),
      .cancel     (wr_csc),
      .load_ok    (val_load),
      .active     (val_active),
      .pending    (val_pending)
   );

   ////////////////////////////////////////////////////////////////////
   // Channel compare, capture and output

   pwm_channel u_chan (
      .pclk       (pclk),
      .presetn    (presetn),
      .cnt        (cnt),
      .modulus    (mod_active),
      .dir_down   (dn),
      .tick       (tick),
      .center     (updn),
      .value      (val_active),
      .mode       (ch_mode),
      .rise_edge  (ch_edge),
      .polarity   (ch_pol),
      .capture_in (capture_in),
      .event_hit  (ch_event),
      .pwm_out    (pwm_out)
   );

   ////////////////////////////////////////////////////////////////////
   // Control registers and flags

   // Arming follows the byte actually returned in the setup phase
   wire rd_tsc_set = rd & hit_tsc & prdata[centered_pulse_output_pkg::TSC_FLAG];
   wire rd_csc_set = rd & hit_csc & prdata[centered_pulse_output_pkg::CSC_FLAG];
   wire [1:0] ovf_nx = flag_step(ovf_flag, ovf_armed, tof_set, rd_tsc_set,
                                 wr_tsc, pwdata[centered_pulse_output_pkg::TSC_FLAG]);
   wire [1:0] ch_nx  = flag_step(ch_flag, ch_armed, ch_event, rd_csc_set,
                                 wr_csc, pwdata[centered_pulse_output_pkg::CSC_FLAG]);

   // Control bytes; flag bits live in their own registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsc <= centered_pulse_output_pkg::TSC_RST;
         csc <= centered_pulse_output_pkg::CSC_RST;
      end else begin
         if (wr_tsc) tsc <= {1'b0, pwdata[6:5], 5'h00};
         if (wr_csc) csc <= {1'b0, pwdata[6:2], 2'h0};
      end
   end

   // Flag state, updated by hardware events and the two-step clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag  <= 1'b0;
         ovf_armed <= 1'b0;
         ch_flag   <= 1'b0;
         ch_armed  <= 1'b0;
      end else begin
         {ovf_flag, ovf_armed} <= ovf_nx;
         {ch_flag, ch_armed}   <= ch_nx;
      end
   end

   // Level request while any enabled flag stands
   assign irq = (ovf_flag & ovf_ie) | (ch_flag & ch_ie);

   ////////////////////////////////////////////////////////////////////
   // Read path; data is captured in the setup phase

   assign rd_byte = hit_tsc  ? {ovf_flag, tsc[6:0]} :
                    hit_cnth ? cnt[15:8] :
                    hit_cntl ? cnt[7:0] :
                    hit_modh ? mod_active[15:8] :
                    hit_modl ? mod_active[7:0] :
                    hit_csc  ? {ch_flag, csc[6:0]} :
                    hit_cvh  ? val_active[15:8] :
                    hit_cvl  ? val_active[7:0] : 8'h00;

   // Read data register, upper bits read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (setup && !pwrite) prdata <= {24'h00_0000, rd_byte};
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Steps of the two-step overflow clear
   sequence s_armed_read;
      rd_tsc_set && !tof_set;
   endsequence

   sequence s_zero_write;
      ovf_armed && wr_tsc && !pwdata[centered_pulse_output_pkg::TSC_FLAG] && !tof_set;
   endsequence

   top_turn_a: assert property (tick && turn && !wr_cnt |=> dn && cnt == $past(mod_active) - 16'h0001)
      else $error("counter did not turn down at modulus");

   floor_turn_a: assert property (tick && updn && dn && cnt == 16'h0001 && !wr_cnt
                                  |=> cnt == 16'h0000 ##1 !dn)
      else $error("counter did not turn up at zero");

   two_step_clear_a: assert property (s_armed_read ##[2:3] s_zero_write |=> !ovf_flag)
      else $error("overflow flag not cleared by read then zero write");

   no_read_clear_a: assert property (ovf_flag && !ovf_armed && wr_tsc |=> ovf_flag)
      else $error("overflow flag cleared without prior read");

   event_wins_a: assert property (tof_set |=> ovf_flag && !ovf_armed)
      else $error("overflow event lost or sequence not reset");

   cnt_clear_a: assert property (wr_cnt |=> cnt == 16'h0000)
      else $error("counter write did not zero counter");

   hold_count_a: assert property (!tick && !wr_cnt |=> $stable(cnt))
      else $error("counter moved without count enable");

   irq_level_a: assert property (ch_flag && ch_ie |-> irq)
      else $error("channel request missing while flag set");

   mod_hold_a: assert property (updn && !tof_set && !wr_tsc |=> $stable(mod_active))
      else $error("modulus loaded outside turnaround");

   mod_cancel_a: assert property (wr_tsc |=> !mod_pending)
      else $error("status write left modulus bytes pending");

   zero_duty_a: assert property (updn && (val_active == 16'h0000 || val_active[15])
                                 |=> pwm_out == $past(ch_pol))
      else $error("zero or negative value did not give 0 percent");

   full_duty_a: assert property (updn && !val_active[15] && val_active > mod_active
                                 |=> pwm_out == !$past(ch_pol))
      else $error("value above modulus did not give 100 percent");

endmodule : center_aligned_pwm_timer

// File: testbench/pwm_load_model.sv
// Load on the PWM pin: counts high cycles and rising edges in a window
`timescale 1ns/1ps
module pwm_load_model (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Pin and window control
   input  wire logic pwm_in,       // Level driven by the timer
   input  wire logic restart,      // Clears both counts
   // Measurements
   output int        high_cycles,  // Cycles seen high since restart
   output int        rise_count    // Low to high changes since restart
);
   logic last;  // Pin level one cycle back

   ////////////////////////////////////////////////////////////////////////
   // Sampling on the clock edge, like a synchronous load would
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_cycles <= 0;
         rise_count  <= 0;
         last        <= 1'b0;
      end else begin
         last <= pwm_in;
         // A restart drops history so each window starts clean
         if (restart) begin
            high_cycles <= 0;
            rise_count  <= 0;
         end else begin
            if (pwm_in) high_cycles <= high_cycles + 1;
            if (pwm_in && !last) rise_count <= rise_count + 1;
         end
      end
   end
endmodule : pwm_load_model

// File: testbench/center_aligned_pwm_timer_tb_top.sv
// Self-checking bench for the centred PWM timer over APB
`timescale 1ns/1ps
module center_aligned_pwm_timer_tb_top;
   ////////////////////////////////////////////////////////////////////////
   // Signals
   logic        pclk;          // 40 MHz bus and counting clock
   logic        presetn;       // Active low reset
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        count_enable;  // Prescaler strobe
   logic        capture_in;
   logic        pwm_out;
   logic        irq;
   logic        restart;       // Opens a load measurement window
   logic        last_err;      // Error answer of the last transfer
   logic [31:0] rd;            // Data of the last read
   int          high_cycles;
   int          rise_count;
   int          n_fail;
   int          n_compared;
   // Centred cases: value, polarity, expected high cycles and rises in 32
   logic [15:0] vals [5] = '{16'h0001, 16'h0001, 16'h0000, 16'h0005, 16'h8001};
   logic [4:0]  pols     = 5'b00010;
   int          exp_hi [5] = '{8, 24, 0, 32, 0};
   int          exp_rs [5] = '{4, 4, 0, 0, 0};

   ////////////////////////////////////////////////////////////////////////
   // Design and load
   center_aligned_pwm_timer dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_enable(count_enable),
      .capture_in(capture_in), .pwm_out(pwm_out), .irq(irq));
   pwm_load_model load (
      .pclk(pclk), .presetn(presetn), .pwm_in(pwm_out), .restart(restart),
      .high_cycles(high_cycles), .rise_count(rise_count));

   // Clock, 25 ns period
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // No wait-state count assumed; only the watchdog ends a dead slave
      while (pready !== 1'b1) @(posedge pclk);
      rd       = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Read a register and compare its byte, upper bits must be zero
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd, {24'h000000, exp});
   endtask : rdc

   // Exactly k counting strobes, then the counter freezes
   task automatic ticks(input int k);
      count_enable <= 1'b1;
      repeat (k) @(posedge pclk);
      count_enable <= 1'b0;
   endtask : ticks

   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // Watchdog, far above the roughly 500 cycles the tests need
   initial begin
      repeat (6000) @(posedge pclk);
      n_fail++;
      report_and_stop;
   end

   ////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 8'h00;
      pwdata       = 32'h00000000;
      count_enable = 1'b0;
      capture_in   = 1'b0;
      restart      = 1'b0;
      n_fail       = 0;
      n_compared   = 0;
      presetn      = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state, then an unmapped write that must change nothing
      rdc(centered_pulse_output_pkg::OFF_TSC, centered_pulse_output_pkg::TSC_RST);
      apb(1'b1, 8'h20, 8'h55);
      chk(last_err, 1'b1);
      rdc(centered_pulse_output_pkg::OFF_MODL, 8'h00);
      chk(last_err, 1'b0);
      // Counter steps only with the strobe; any byte write zeroes it
      ticks(3);
      rdc(centered_pulse_output_pkg::OFF_CNTL, 8'h03);
      wr(centered_pulse_output_pkg::OFF_CNTH, 8'h5A);
      rdc(centered_pulse_output_pkg::OFF_CNTL, 8'h00);
      // Modulus 4, in the legal centred range, loads at once in up mode
      wr(centered_pulse_output_pkg::OFF_MODH, 8'h00);
      wr(centered_pulse_output_pkg::OFF_MODL, 8'h04);
      rdc(centered_pulse_output_pkg::OFF_MODL, 8'h04);
      // Up-count wrap from modulus to zero, then two-step clear
      ticks(5);
      rdc(centered_pulse_output_pkg::OFF_CNTL, 8'h00);
      rdc(centered_pulse_output_pkg::OFF_TSC, 8'h80);
      wr(centered_pulse_output_pkg::OFF_TSC, 8'h00);
      rdc(centered_pulse_output_pkg::OFF_TSC, 8'h00);
      // Single byte stays buffered; control write drops the pair
      wr(centered_pulse_output_pkg::OFF_MODH, 8'h01);
      rdc(centered_pulse_output_pkg::OFF_MODH, 8'h00);
      wr(centered_pulse_output_pkg::OFF_TSC, 8'h00);
      wr(centered_pulse_output_pkg::OFF_MODL, 8'h08);
      rdc(centered_pulse_output_pkg::OFF_MODL, 8'h04);
      wr(centered_pulse_output_pkg::OFF_TSC, 8'h00);
      // Compare mode with enable: match at 2 sets flag and request
      wr(centered_pulse_output_pkg::OFF_CSC, 8'h50);
      wr(centered_pulse_output_pkg::OFF_CVH, 8'h00);
      wr(centered_pulse_output_pkg::OFF_CVL, 8'h02);
      wr(centered_pulse_output_pkg::OFF_CNTL, 8'h00);
      ticks(3);
      @(negedge pclk);
      chk(irq, 1'b1);
      rdc(centered_pulse_output_pkg::OFF_CSC, 8'hD0);
      wr(centered_pulse_output_pkg::OFF_CSC, 8'h50);
      @(negedge pclk);
      chk(irq, 1'b0);
      // Channel control write drops a half-written value
      wr(centered_pulse_output_pkg::OFF_CVH, 8'h00);
      wr(centered_pulse_output_pkg::OFF_CSC, 8'h50);
      wr(centered_pulse_output_pkg::OFF_CVL, 8'h03);
      rdc(centered_pulse_output_pkg::OFF_CVL, 8'h02);
      // Capture on a rising pin edge
      wr(centered_pulse_output_pkg::OFF_CSC, 8'h08);
      capture_in <= 1'b1;
      repeat (3) @(posedge pclk);
      rdc(centered_pulse_output_pkg::OFF_CSC, 8'h88);
      wr(centered_pulse_output_pkg::OFF_CSC, 8'h08);
      rdc(centered_pulse_output_pkg::OFF_CSC, 8'h08);
      capture_in <= 1'b0;
      // Centred mode: new value waits for the turnaround
      wr(centered_pulse_output_pkg::OFF_TSC, 8'h20);
      wr(centered_pulse_output_pkg::OFF_CNTL, 8'h00);
      wr(centered_pulse_output_pkg::OFF_CSC, 8'h20);
      wr(centered_pulse_output_pkg::OFF_CVH, 8'h00);
      wr(centered_pulse_output_pkg::OFF_CVL, 8'h01);
      rdc(centered_pulse_output_pkg::OFF_CVL, 8'h02);
      count_enable <= 1'b1;
      repeat (20) @(posedge pclk);
      rdc(centered_pulse_output_pkg::OFF_CVL, 8'h01);
      rdc(centered_pulse_output_pkg::OFF_TSC, 8'hA0);
      // Writing a one keeps the flag; the enabled flag raises the request
      wr(centered_pulse_output_pkg::OFF_TSC, 8'hE0);
      @(negedge pclk);
      chk(irq, 1'b1);
      // Duty and period per case, four periods of 8 cycles each
      for (int i = 0; i < 5; i++) begin
         wr(centered_pulse_output_pkg::OFF_CSC, {4'h2, 1'b0, pols[i], 2'b00});
         wr(centered_pulse_output_pkg::OFF_CVH, vals[i][15:8]);
         wr(centered_pulse_output_pkg::OFF_CVL, vals[i][7:0]);
         repeat (24) @(posedge pclk);
         restart <= 1'b1;
         @(posedge pclk);
         restart <= 1'b0;
         repeat (32) @(posedge pclk);
         @(negedge pclk);
         chk(high_cycles, exp_hi[i]);
         chk(rise_count, exp_rs[i]);
      end
      report_and_stop;
   end
endmodule : center_aligned_pwm_timer_tb_top
